// ===== verilog/ljr_defines.svh
// offsets, field positions, reset values and timing counts of the register slice
`ifndef LJR_DEFINES_SVH
`define LJR_DEFINES_SVH

// ===========================================
// address layout
`define LJR_PAGE_MSB 11
`define LJR_PAGE_LSB 8
`define LJR_PAGE_GLOBAL 4'h0
`define LJR_OFF_CHAN_IRQ 8'h09
`define LJR_OFF_TIMER_EN 8'h0c
`define LJR_OFF_TIMER_STAT 8'h0d
`define LJR_OFF_LINE_STD 8'h20
`define LJR_OFF_TXJA_CFG 8'h21
`define LJR_OFF_JIT_MEAS 8'h2f

// ===========================================
// field positions
`define LJR_TIMER_EN_BIT 0
`define LJR_TIMER_STAT_BIT 0
`define LJR_LINE_STD_BIT 0
`define LJR_TXJA_MEASURE_BIT 5
`define LJR_TXJA_LIMIT_BIT 4
`define LJR_TXJA_ENABLE_BIT 3
`define LJR_TXJA_DEPTH_MSB 2
`define LJR_TXJA_DEPTH_LSB 1
`define LJR_TXJA_BW_BIT 0

// ===========================================
// reset values
`define LJR_CHAN_IRQ_RST 8'h00
`define LJR_TIMER_EN_RST 1'h0
`define LJR_TIMER_STAT_RST 1'h0
`define LJR_LINE_STD_RST 1'h0
`define LJR_TXJA_RST 6'h10

// ===========================================
// depth codes and buffer sizes in bits
`define LJR_DEPTH_CODE_128 2'h0
`define LJR_DEPTH_CODE_64 2'h1
`define LJR_DEPTH_BITS_128 8'h80
`define LJR_DEPTH_BITS_64 8'h40
`define LJR_DEPTH_BITS_32 8'h20

// ===========================================
// timing
`define LJR_SECOND_NS 1000000000
`define LJR_CLK_PERIOD_NS 10
`define LJR_SECOND_CYCLES (`LJR_SECOND_NS / `LJR_CLK_PERIOD_NS)

`endif

// ===== verilog/ljr_pkg.sv
// types shared by the register slice modules
package ljr_pkg;
    typedef logic [5:0] ljr_txja_type;
    typedef logic [7:0] ljr_byte_type;
    typedef struct packed {
        logic hit;
        logic [3:0] idx;
    } ljr_chan_sel_type;
endpackage

// ===== verilog/ljr_jit_if.sv
// link between the register slice and one jitter peak tracker
`timescale 1ns/100ps
`default_nettype none
interface ljr_jit_if #(parameter int SW = 8);
    logic [SW-1:0] sample;
    logic sample_valid;
    logic accum_mode;
    logic read_clr;
    logic [SW-1:0] value;
    modport ctrl (output sample, output sample_valid, output accum_mode, output read_clr, input value);
    modport tracker (input sample, input sample_valid, input accum_mode, input read_clr, output value);
endinterface
`default_nettype wire

// ===== verilog/ljr_jitter_peak.sv
// measured jitter value holder: real-time or peak since last read
`timescale 1ns/100ps
`default_nettype none
module ljr_jitter_peak #(
    parameter int SW = 8
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    ljr_jit_if.tracker jit
);
    logic [SW-1:0] value_d;
    logic [SW-1:0] value_q;

    // ===========================================
    // next value
    always_comb begin
        value_d = value_q;
        if (!jit.accum_mode) begin
            if (jit.sample_valid) begin
                value_d = jit.sample;
            end
        end else begin
            // a read restarts the peak; a sample in that cycle seeds it
            if (jit.read_clr) begin
                value_d = jit.sample_valid ? jit.sample : '0;
            end else if (jit.sample_valid && jit.sample > value_q) begin
                value_d = jit.sample;
            end
        end
    end

    // ===========================================
    // register
    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            value_q <= '0;
        end else begin
            value_q <= value_d;
        end
    end

    assign jit.value = value_q;
endmodule
`default_nettype wire

// ===== verilog/ljr_regs.sv
// interrupt indication, second timer, line standard and tx jitter attenuator registers
`include "ljr_defines.svh"
`timescale 1ns/100ps
`default_nettype none
module ljr_regs #(
    parameter int NCH = 8,
    parameter int SW = 8,
    parameter int SECOND_CYCLES = `LJR_SECOND_CYCLES
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [11:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    output logic [7:0] rdata_out,
    input wire logic [NCH-1:0] chan_irq_pend_in,
    input wire logic [NCH*SW-1:0] jit_sample_in,
    input wire logic [NCH-1:0] jit_sample_valid_in,
    output logic irq_out,
    output logic timer_irq_req_out,
    output logic [NCH-1:0] line_standard_out,
    output logic [NCH-1:0] tx_jitter_measure_mode_out,
    output logic [NCH-1:0] tx_atten_limit_mode_out,
    output logic [NCH-1:0] tx_atten_enable_out,
    output logic [2*NCH-1:0] tx_atten_depth_out,
    output logic [8*NCH-1:0] tx_atten_depth_bits_out,
    output logic [NCH-1:0] tx_atten_bandwidth_out
);
    localparam int CW = $clog2(SECOND_CYCLES);

    // ===========================================
    // address decode, shared by write and read paths
    function automatic ljr_pkg::ljr_chan_sel_type chan_sel(input logic [11:0] a);
        ljr_pkg::ljr_chan_sel_type s;
        s.idx = a[`LJR_PAGE_MSB:`LJR_PAGE_LSB] - 4'h1;
        s.hit = (a[`LJR_PAGE_MSB:`LJR_PAGE_LSB] != `LJR_PAGE_GLOBAL) &&
                ({1'b0, a[`LJR_PAGE_MSB:`LJR_PAGE_LSB]} <= 5'(NCH));
        return s;
    endfunction

    function automatic logic [7:0] depth_bits(input logic [1:0] code);
        logic [7:0] b;
        b = `LJR_DEPTH_BITS_32;
        if (code == `LJR_DEPTH_CODE_128) begin
            b = `LJR_DEPTH_BITS_128;
        end else if (code == `LJR_DEPTH_CODE_64) begin
            b = `LJR_DEPTH_BITS_64;
        end
        return b;
    endfunction

    ljr_pkg::ljr_chan_sel_type sel;
    logic global_hit;
    logic [7:0] off;

    always_comb begin
        sel = chan_sel(addr_in);
        global_hit = (addr_in[`LJR_PAGE_MSB:`LJR_PAGE_LSB] == `LJR_PAGE_GLOBAL);
        off = addr_in[7:0];
    end

    // ===========================================
    // one second divider and timer flag
    logic [CW-1:0] sec_cnt_d;
    logic [CW-1:0] sec_cnt_q;
    logic tick_d;
    logic tick_q;
    logic timer_en_d;
    logic timer_en_q;
    logic timer_flag_d;
    logic timer_flag_q;

    always_comb begin
        tick_d = 1'b0;
        sec_cnt_d = sec_cnt_q + 1'b1;
        if (sec_cnt_q == CW'(SECOND_CYCLES - 1)) begin
            sec_cnt_d = '0;
            tick_d = 1'b1;
        end
        timer_en_d = timer_en_q;
        if (wr_in && global_hit && off == `LJR_OFF_TIMER_EN) begin
            timer_en_d = wdata_in[`LJR_TIMER_EN_BIT];
        end
        timer_flag_d = timer_flag_q;
        if (wr_in && global_hit && off == `LJR_OFF_TIMER_STAT && wdata_in[`LJR_TIMER_STAT_BIT]) begin
            timer_flag_d = 1'b0;
        end
        // expiry wins over a clear in the same cycle
        if (tick_q) begin
            timer_flag_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            sec_cnt_q <= '0;
            tick_q <= 1'b0;
            timer_en_q <= `LJR_TIMER_EN_RST;
            timer_flag_q <= `LJR_TIMER_STAT_RST;
        end else begin
            sec_cnt_q <= sec_cnt_d;
            tick_q <= tick_d;
            timer_en_q <= timer_en_d;
            timer_flag_q <= timer_flag_d;
        end
    end

    // ===========================================
    // channel interrupt indication
    // follows the channels' pending level, so no software clear exists here
    logic [NCH-1:0] chan_flags_d;
    logic [NCH-1:0] chan_flags_q;
    logic irq_d;
    logic irq_q;
    logic treq_d;
    logic treq_q;

    always_comb begin
        chan_flags_d = chan_irq_pend_in;
        treq_d = timer_flag_d & timer_en_d;
        irq_d = treq_d | (|chan_flags_d);
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            chan_flags_q <= '0;
            treq_q <= 1'b0;
            irq_q <= 1'b0;
        end else begin
            chan_flags_q <= chan_flags_d;
            treq_q <= treq_d;
            irq_q <= irq_d;
        end
    end

    // ===========================================
    // per-channel line standard and tx jitter attenuator config
    logic [NCH-1:0] line_std_d;
    logic [NCH-1:0] line_std_q;
    ljr_pkg::ljr_txja_type txja_d [NCH];
    ljr_pkg::ljr_txja_type txja_q [NCH];
    logic [8*NCH-1:0] dbits_d;
    logic [8*NCH-1:0] dbits_q;
    logic [NCH-1:0] jit_clr;
    logic [SW-1:0] jit_val [NCH];

    always_comb begin
        line_std_d = line_std_q;
        for (int i = 0; i < NCH; i++) begin
            txja_d[i] = txja_q[i];
        end
        if (wr_in && sel.hit && off == `LJR_OFF_LINE_STD) begin
            line_std_d[sel.idx[2:0]] = wdata_in[`LJR_LINE_STD_BIT];
        end
        if (wr_in && sel.hit && off == `LJR_OFF_TXJA_CFG) begin
            txja_d[sel.idx[2:0]] = wdata_in[5:0];
        end
        for (int i = 0; i < NCH; i++) begin
            dbits_d[8*i +: 8] = depth_bits(txja_d[i][`LJR_TXJA_DEPTH_MSB:`LJR_TXJA_DEPTH_LSB]);
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            line_std_q <= {NCH{`LJR_LINE_STD_RST}};
            for (int i = 0; i < NCH; i++) begin
                txja_q[i] <= `LJR_TXJA_RST;
            end
            dbits_q <= {NCH{`LJR_DEPTH_BITS_128}};
        end else begin
            line_std_q <= line_std_d;
            for (int i = 0; i < NCH; i++) begin
                txja_q[i] <= txja_d[i];
            end
            dbits_q <= dbits_d;
        end
    end

    // ===========================================
    // jitter trackers, one per channel
    ljr_jit_if #(.SW(SW)) jit [NCH] ();

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_jit
            assign jit[g].sample = jit_sample_in[SW*g +: SW];
            assign jit[g].sample_valid = jit_sample_valid_in[g];
            assign jit[g].accum_mode = txja_q[g][`LJR_TXJA_MEASURE_BIT];
            assign jit[g].read_clr = jit_clr[g];
            assign jit_val[g] = jit[g].value;
            ljr_jitter_peak #(.SW(SW)) u_peak (
                .clk_in(clk_in),
                .nrst_in(nrst_in),
                .jit(jit[g].tracker)
            );
        end
    endgenerate

    // a read of the measured value restarts the accumulated peak
    always_comb begin
        jit_clr = '0;
        if (rd_in && sel.hit && off == `LJR_OFF_JIT_MEAS) begin
            jit_clr[sel.idx[2:0]] = 1'b1;
        end
    end

    // ===========================================
    // read data, one cycle after the strobe
    logic [7:0] rdata_d;
    logic [7:0] rdata_q;

    always_comb begin
        rdata_d = rdata_q;
        if (rd_in) begin
            rdata_d = 8'h00;
            if (global_hit) begin
                unique case (off)
                    `LJR_OFF_CHAN_IRQ: rdata_d = 8'(chan_flags_q);
                    `LJR_OFF_TIMER_EN: rdata_d = {7'h00, timer_en_q};
                    `LJR_OFF_TIMER_STAT: rdata_d = {7'h00, timer_flag_q};
                    default: rdata_d = 8'h00;
                endcase
            end else if (sel.hit) begin
                unique case (off)
                    `LJR_OFF_LINE_STD: rdata_d = {7'h00, line_std_q[sel.idx[2:0]]};
                    `LJR_OFF_TXJA_CFG: rdata_d = {2'h0, txja_q[sel.idx[2:0]]};
                    `LJR_OFF_JIT_MEAS: rdata_d = 8'(jit_val[sel.idx[2:0]]);
                    default: rdata_d = 8'h00;
                endcase
            end
        end
    end

    always_ff @(posedge clk_in or negedge nrst_in) begin
        if (!nrst_in) begin
            rdata_q <= 8'h00;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    // ===========================================
    // outputs
    assign rdata_out = rdata_q;
    assign irq_out = irq_q;
    assign timer_irq_req_out = treq_q;
    assign line_standard_out = line_std_q;
    assign tx_atten_depth_bits_out = dbits_q;

    generate
        for (genvar g = 0; g < NCH; g++) begin : g_out
            assign tx_jitter_measure_mode_out[g] = txja_q[g][`LJR_TXJA_MEASURE_BIT];
            assign tx_atten_limit_mode_out[g] = txja_q[g][`LJR_TXJA_LIMIT_BIT];
            assign tx_atten_enable_out[g] = txja_q[g][`LJR_TXJA_ENABLE_BIT];
            assign tx_atten_depth_out[2*g +: 2] = txja_q[g][`LJR_TXJA_DEPTH_MSB:`LJR_TXJA_DEPTH_LSB];
            assign tx_atten_bandwidth_out[g] = txja_q[g][`LJR_TXJA_BW_BIT];
        end
    endgenerate
endmodule
`default_nettype wire

// ===== verif/ljr_host_model.sv
// host processor model driving the register access port
`timescale 1ns/100ps
`default_nettype none
module ljr_host_model (
    input wire logic clk_in,
    input wire logic [7:0] rdata_in,
    output logic [11:0] addr_out,
    output logic wr_out,
    output logic rd_out,
    output logic [7:0] wdata_out
);
    initial begin
        addr_out = 12'h000;
        wr_out = 1'b0;
        rd_out = 1'b0;
        wdata_out = 8'h00;
    end

    // ===========================================
    // bus cycles: one strobe cycle, address and data held across the sampling edge
    task automatic put(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        wdata_out = d;
        wr_out = 1'b1;
        @(posedge clk_in);
        #1;
        wr_out = 1'b0;
        // released data flips so a stale value is never mistaken for a write
        wdata_out = ~d;
    endtask

    task automatic get(input logic [11:0] a, output logic [7:0] d);
        @(posedge clk_in);
        #1;
        addr_out = a;
        rd_out = 1'b1;
        @(posedge clk_in);
        #1;
        rd_out = 1'b0;
        d = rdata_in;
    endtask
endmodule
`default_nettype wire

// ===== verif/ljr_regs_chk.sv
// concurrent checks on the register slice ports
`timescale 1ns/100ps
`default_nettype none
module ljr_regs_chk #(
    parameter int NCH = 8,
    parameter int SW = 8,
    parameter int SECOND_CYCLES = 20
) (
    input wire logic clk_in,
    input wire logic nrst_in,
    input wire logic [11:0] addr_in,
    input wire logic wr_in,
    input wire logic rd_in,
    input wire logic [7:0] wdata_in,
    input wire logic [7:0] rdata_out,
    input wire logic [NCH-1:0] chan_irq_pend_in,
    input wire logic irq_out,
    input wire logic timer_irq_req_out,
    input wire logic [NCH-1:0] line_standard_out,
    input wire logic [NCH-1:0] tx_jitter_measure_mode_out,
    input wire logic [NCH-1:0] tx_atten_limit_mode_out,
    input wire logic [NCH-1:0] tx_atten_enable_out,
    input wire logic [2*NCH-1:0] tx_atten_depth_out,
    input wire logic [8*NCH-1:0] tx_atten_depth_bits_out,
    input wire logic [NCH-1:0] tx_atten_bandwidth_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (!nrst_in);

    // ===========================================
    // global registers
    chan_irq_a: assert property (|chan_irq_pend_in |=> irq_out)
        else $error("channel pending did not raise irq");
    chan_read_a: assert property (rd_in && addr_in == 12'h009 |=> rdata_out == $past(chan_irq_pend_in, 2))
        else $error("channel flags read wrong");
    timer_mask_a: assert property (wr_in && addr_in == 12'h00c && !wdata_in[0] |=> ##1 !timer_irq_req_out)
        else $error("masked timer still requests");
    timer_irq_a: assert property (timer_irq_req_out |-> irq_out)
        else $error("timer request missing on irq");
    zero_keep_a: assert property (timer_irq_req_out && wr_in && addr_in == 12'h00d && !wdata_in[0]
        |=> timer_irq_req_out)
        else $error("zero write cleared timer flag");
    reset_vals_a: assert property ($rose(nrst_in) |->
        tx_atten_limit_mode_out == '1 && tx_atten_enable_out == '0 && line_standard_out == '0 &&
        tx_atten_depth_out == '0 && tx_atten_bandwidth_out == '0 && tx_jitter_measure_mode_out == '0 &&
        irq_out == 1'b0)
        else $error("wrong reset values");

    // ===========================================
    // per channel registers
    for (genvar g = 0; g < NCH; g++) begin : ch
        line_std_a: assert property (wr_in && addr_in == {4'(g + 1), 8'h20} |=>
            line_standard_out[g] == $past(wdata_in[0]))
            else $error("line standard bit not written");
        cfg_a: assert property (wr_in && addr_in == {4'(g + 1), 8'h21} |=>
            {tx_jitter_measure_mode_out[g], tx_atten_limit_mode_out[g], tx_atten_enable_out[g],
            tx_atten_depth_out[2*g+:2], tx_atten_bandwidth_out[g]} == $past(wdata_in[5:0]))
            else $error("tx attenuator config not written");
        depth_a: assert property (tx_atten_depth_bits_out[8*g+:8] ==
            (tx_atten_depth_out[2*g+:2] == 2'h0 ? 8'h80 : tx_atten_depth_out[2*g+:2] == 2'h1 ? 8'h40 : 8'h20))
            else $error("buffer size does not match depth code");
    end
endmodule
bind ljr_regs ljr_regs_chk #(.NCH(NCH), .SW(SW), .SECOND_CYCLES(SECOND_CYCLES)) ljr_regs_chk_i (.clk_in(clk_in),
    .nrst_in(nrst_in), .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
    .chan_irq_pend_in(chan_irq_pend_in), .irq_out(irq_out), .timer_irq_req_out(timer_irq_req_out),
    .line_standard_out(line_standard_out), .tx_jitter_measure_mode_out(tx_jitter_measure_mode_out),
    .tx_atten_limit_mode_out(tx_atten_limit_mode_out), .tx_atten_enable_out(tx_atten_enable_out),
    .tx_atten_depth_out(tx_atten_depth_out), .tx_atten_depth_bits_out(tx_atten_depth_bits_out),
    .tx_atten_bandwidth_out(tx_atten_bandwidth_out));
`default_nettype wire

// ===== verif/tb.sv
// self-checking bench for the register slice
`timescale 1ns/100ps
`default_nettype none
module tb;
    localparam int NCH = 8;
    localparam int SW = 8;
    logic clk_in, nrst_in, wr_in, rd_in, irq_out, timer_irq_req_out;
    logic [11:0] addr_in;
    logic [7:0] wdata_in, rdata_out, rd_v;
    logic [NCH-1:0] pend, jit_vld, line_std, meas, lim, ena, bw;
    logic [NCH*SW-1:0] jit_smp;
    logic [2*NCH-1:0] depth;
    logic [8*NCH-1:0] depth_bits;
    logic [7:0] cfg_v [4] = '{8'h29, 8'h12, 8'h0d, 8'h36};
    logic [7:0] exp_bits [4] = '{8'h80, 8'h40, 8'h20, 8'h20};
    int err_total;
    int num_checks;

    // short second keeps the run brief
    ljr_regs #(.NCH(NCH), .SW(SW), .SECOND_CYCLES(20)) ljr_regs_i (.clk_in(clk_in), .nrst_in(nrst_in),
        .addr_in(addr_in), .wr_in(wr_in), .rd_in(rd_in), .wdata_in(wdata_in), .rdata_out(rdata_out),
        .chan_irq_pend_in(pend), .jit_sample_in(jit_smp), .jit_sample_valid_in(jit_vld), .irq_out(irq_out),
        .timer_irq_req_out(timer_irq_req_out), .line_standard_out(line_std), .tx_jitter_measure_mode_out(meas),
        .tx_atten_limit_mode_out(lim), .tx_atten_enable_out(ena), .tx_atten_depth_out(depth),
        .tx_atten_depth_bits_out(depth_bits), .tx_atten_bandwidth_out(bw));
    ljr_host_model ljr_host_model_i (.clk_in(clk_in), .rdata_in(rdata_out), .addr_out(addr_in),
        .wr_out(wr_in), .rd_out(rd_in), .wdata_out(wdata_in));

    initial begin
        clk_in = 1'b0;
        forever #5 clk_in = ~clk_in;
    end

    // ===========================================
    // helpers
    task automatic chk(input logic [63:0] got, input logic [63:0] exp);
        num_checks++;
        if (got !== exp) begin
            err_total++;
            $display("Error at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask
    task automatic rchk(input logic [11:0] a, input logic [7:0] exp);
        ljr_host_model_i.get(a, rd_v);
        chk(rd_v, exp);
    endtask
    task automatic close_out;
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic jit(input logic [7:0] v);
        jit_smp[7:0] = v;
        jit_vld[0] = 1'b1;
        cyc(1);
        // strobe drops for a full cycle so back-to-back samples never retoggle it in one step
        jit_vld[0] = 1'b0;
        cyc(1);
    endtask

    // ===========================================
    // scenarios
    initial begin
        nrst_in = 1'b0;
        pend = '0;
        jit_smp = '0;
        jit_vld = '0;
        err_total = 0;
        num_checks = 0;
        cyc(16);
        nrst_in = 1'b1;
        rchk(12'h009, 8'h00);
        rchk(12'h00d, 8'h00);
        rchk(12'h120, 8'h00);
        rchk(12'h821, 8'h10);
        chk(depth_bits, {NCH{8'h80}});
        ljr_host_model_i.put(12'h00c, 8'h01);
        rchk(12'h00c, 8'h01);
        // bounded wait for the first expiry; next one is a full second away
        for (int i = 0; timer_irq_req_out !== 1'b1; i++) begin
            if (i == 40) begin
                err_total++;
                close_out();
            end
            cyc(1);
        end
        chk(irq_out, 1'b1);
        rchk(12'h00d, 8'h01);
        ljr_host_model_i.put(12'h00d, 8'h00);
        rchk(12'h00d, 8'h01);
        ljr_host_model_i.put(12'h00d, 8'h01);
        chk(timer_irq_req_out, 1'b0);
        rchk(12'h00d, 8'h00);
        ljr_host_model_i.put(12'h00c, 8'h00);
        cyc(25);
        chk(timer_irq_req_out, 1'b0);
        rchk(12'h00d, 8'h01);
        pend = 8'h81;
        cyc(2);
        chk(irq_out, 1'b1);
        rchk(12'h009, 8'h81);
        pend = 8'h00;
        cyc(2);
        chk(irq_out, 1'b0);
        ljr_host_model_i.put(12'h009, 8'hff);
        rchk(12'h009, 8'h00);
        rchk(12'h900, 8'h00);
        for (int g = 0; g < NCH; g++) ljr_host_model_i.put({4'(g + 1), 8'h20}, 8'(g % 2));
        chk(line_std, 8'haa);
        rchk(12'h220, 8'h01);
        for (int c = 0; c < 4; c++) begin
            ljr_host_model_i.put(12'h321, cfg_v[c]);
            chk({meas[2], lim[2], ena[2], depth[5:4], bw[2]}, cfg_v[c][5:0]);
            chk(depth_bits[23:16], exp_bits[c]);
            rchk(12'h321, cfg_v[c]);
        end
        ljr_host_model_i.put(12'h121, 8'h30);
        jit(8'h05);
        jit(8'h09);
        jit(8'h03);
        rchk(12'h12f, 8'h09);
        rchk(12'h12f, 8'h00);
        ljr_host_model_i.put(12'h121, 8'h10);
        jit(8'h05);
        jit(8'h09);
        jit(8'h03);
        rchk(12'h12f, 8'h03);
        // ===========================================
        // mid-run reset restores every written field to its default
        nrst_in = 1'b0;
        cyc(2);
        chk({lim, ena, line_std}, 24'hff0000);
        chk({bw, depth}, 24'h000000);
        chk(depth_bits, {NCH{8'h80}});
        nrst_in = 1'b1;
        rchk(12'h321, 8'h10);
        rchk(12'h00c, 8'h00);
        close_out();
    end
endmodule
`default_nettype wire
